/* File: verilog/scb_pkg.sv */
// Package: constants and types for the scan capture buffer and scan-length counter
// Behaviour
// - Terminal count closes a partial byte and switches register; unshifted bits are dropped.
// - Incoming data is double-buffered in two 8-bit registers as a FIFO.
// - Returning test data is sampled on the rising test clock edge.
// - Capture read completes only when not empty and compactor off.
// - Capture writes are accepted only in compactor mode.
// - Shift only with capture enabled, clocking permitted and, outside compactor mode, buffer not full.
// - Capture switches register after eight bits are shifted in.
// - Capture also switches register on enabled counter terminal count, if the byte already holds or takes a bit.
// - New bits enter at the MSB and move toward bit zero.
// - Capture buffer can act as a 16-bit serial signature compactor.
// - Compactor seeded by two writes, most significant byte first.
// - Seed writes accepted any time in compactor mode; shifting waits until both bytes loaded.
// - Leaving compactor mode makes buffer full; MSB byte is read first.
// - Two-bit loop-back field selects the capture input source.
// - Loop-back does not stop clocking or outgoing shifting.
// - Counter is 32-bit down-counter of four bytes, loadable when disabled.
// - Counter loads by four writes, LSB first; other writes restart sequencing.
// - Counter cleared at terminal count and hard reset, not soft reset.
// - All four counter bytes are readable live, without a shadow copy.
// - Single step decrements for exactly one cycle; no shift clocking.
// - Counter saturates at zero instead of wrapping.
// - Outgoing data changes a half cycle before capture samples it.
package scb_pkg;
  localparam logic [3:0]  ADR_CAPTURE  = 4'h0;
  localparam logic [3:0]  ADR_MODE_ONE = 4'h1;
  localparam logic [3:0]  ADR_MODE_TWO = 4'h2;
  localparam logic [3:0]  ADR_STATUS   = 4'h3;
  localparam logic [3:0]  ADR_CNT_B0   = 4'h4;
  localparam logic [3:0]  ADR_CNT_B1   = 4'h5;
  localparam logic [3:0]  ADR_CNT_B2   = 4'h6;
  localparam logic [3:0]  ADR_CNT_B3   = 4'h7;
  localparam int          M1_CAP_EN    = 2;
  localparam int          M1_SSC_EN    = 3;
  localparam int          M1_CNT_EN    = 4;
  localparam int          M2_STEP      = 0;
  localparam int          M2_SOFT_RST  = 1;
  localparam logic [7:0]  MODE_ONE_RST = 8'h00;
  localparam logic [7:0]  MODE_TWO_RST = 8'h00;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  localparam logic [15:0] SSC_POLY     = 16'h1021;
  localparam logic [31:0] CNT_RST      = 32'h0000_0000;
  typedef enum logic [1:0] {
    SCB_LB_EXT  = 2'h0,
    SCB_LB_MSA  = 2'h1,
    SCB_LB_MSB  = 2'h2,
    SCB_LB_DATA = 2'h3
  } scb_loop_t;
  typedef enum logic [2:0] {
    SCB_SEED_HI   = 3'b001,
    SCB_SEED_LO   = 3'b010,
    SCB_SEED_DONE = 3'b100
  } scb_seed_t;
endpackage : scb_pkg

/* File: verilog/scb_scan_counter.sv */
// Scan-length counter: 32-bit saturating down-counter with byte-wise loading
`timescale 1ns/1ps
`default_nettype none
module scb_scan_counter
  import scb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic        seq_clr,
  input  wire logic [7:0]  data,
  input  wire logic        dec,
  output logic      [31:0] count,
  output logic             tc
);
  logic [1:0] lane;

  // Last decrement: the count lands on zero, which is its cleared state
  assign tc = dec && (count == 32'h0000_0001);

  always_ff @(posedge clk) begin
    if (rst || seq_clr) begin
      lane <= 2'h0;
    end else if (load) begin
      lane <= lane + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= CNT_RST;
    end else if (load) begin
      count[lane*8 +: 8] <= data;
    end else if (dec && count != 32'h0000_0000) begin
      count <= count - 32'h0000_0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_cnt_saturate: assert property (dec && !load && count == 32'h0 |=> count == 32'h0)
    else $error("counter wrapped below zero");
  a_cnt_decrement: assert property (dec && !load && count != 32'h0
    |=> count == $past(count) - 32'h1)
    else $error("counter did not decrement by one");
  a_cnt_lsb_first: assert property (seq_clr ##1 (!load && !seq_clr) ##1 load
    |=> count[7:0] == $past(data))
    else $error("first load byte not in low lane");
endmodule : scb_scan_counter
`default_nettype wire

/* File: verilog/scb_capture.sv */
// Capture buffer, signature compactor and loop-back input for the scan test bus master
`timescale 1ns/1ps
`default_nettype none
module scb_capture
  import scb_pkg::*;
(
  input  wire logic       CLK_SYS,
  input  wire logic       RESET,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       TDI,
  input  wire logic       TCK,
  input  wire logic       TCK_PERMIT,
  input  wire logic       TMS_A_OUT,
  input  wire logic       TMS_B_OUT,
  input  wire logic       TDO_OUT,
  output logic            CAPTURE_FULL,
  output logic            CAPTURE_EMPTY,
  output logic            TERM_COUNT
);
  logic [7:0]  mode_one;
  logic [7:0]  mode_two;
  logic        soft_rst;
  logic        step_pulse;
  logic        step_prev;
  logic [2:0]  tdi_sync;
  logic [2:0]  tck_sync;
  logic        tck_rise;
  logic        din;
  logic        cap_en;
  logic        ssc_on;
  logic        ssc_prev;
  logic        ssc_rise;
  logic        ssc_fall;
  scb_seed_t   seed_state;
  scb_seed_t   next_seed;
  logic        seed_wr;
  logic [7:0]  cap_reg [2];
  logic [1:0]  valid;
  logic        wsel;
  logic        rsel;
  logic [2:0]  bit_cnt;
  logic        full;
  logic        empty;
  logic        cap_shift;
  logic        byte_done;
  logic        rd_ok;
  logic        ctr_dec;
  logic        ctr_tc;
  logic        ctr_load;
  logic        ctr_seq_clr;
  logic [31:0] ctr_count;
  logic [15:0] sig;
  logic [15:0] next_sig;
  logic [7:0]  next_rdata;

  // Compactor step: shift left, fold incoming bit with the MSB into the taps
  function automatic logic [15:0] ssc_step(input logic [15:0] s, input logic b);
    logic fb;
    fb = s[15] ^ b;
    ssc_step = {s[14:0], 1'b0} ^ (fb ? SSC_POLY : 16'h0000);
  endfunction : ssc_step

  // Pins from the scan chain pass two flops; the third only feeds edge detection
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      tdi_sync <= 3'h7;
      tck_sync <= 3'h0;
    end else begin
      tdi_sync <= {tdi_sync[1:0], TDI};
      tck_sync <= {tck_sync[1:0], TCK};
    end
  end

  assign tck_rise = tck_sync[1] && !tck_sync[2];

  // Outgoing shifters settle on the falling edge, so same-clock sampling is safe
  always_comb begin
    unique case (scb_loop_t'(mode_one[1:0]))
      SCB_LB_EXT:  din = tdi_sync[1];
      SCB_LB_MSA:  din = TMS_A_OUT;
      SCB_LB_MSB:  din = TMS_B_OUT;
      SCB_LB_DATA: din = TDO_OUT;
    endcase
  end

  assign cap_en   = mode_one[M1_CAP_EN];
  assign ssc_on   = mode_one[M1_SSC_EN];
  assign ssc_rise = ssc_on && !ssc_prev;
  assign ssc_fall = !ssc_on && ssc_prev;

  // Mode registers; soft reset bit self-clears and never reaches the counter
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      mode_one <= MODE_ONE_RST;
    end else if (WR && ADDR == ADR_MODE_ONE) begin
      mode_one <= WDATA;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      mode_two <= MODE_TWO_RST;
    end else if (WR && ADDR == ADR_MODE_TWO) begin
      mode_two <= WDATA;
    end else begin
      mode_two[M2_SOFT_RST] <= 1'b0;
    end
  end

  assign soft_rst = mode_two[M2_SOFT_RST];

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ssc_prev  <= 1'b0;
      step_prev <= 1'b0;
    end else begin
      ssc_prev  <= ssc_on;
      step_prev <= mode_two[M2_STEP];
    end
  end

  // One decrement when the step bit rises; held bit keeps shifting off
  assign step_pulse = mode_two[M2_STEP] && !step_prev;

  // Loop-back never gates the clock permit, so outgoing shifting goes on
  assign ctr_dec = (mode_one[M1_CNT_EN] && tck_rise && TCK_PERMIT
                    && !mode_two[M2_STEP]) || step_pulse;

  assign ctr_load    = WR && ADDR == ADR_CNT_B0;
  assign ctr_seq_clr = WR && ADDR != ADR_CNT_B0;

  scb_scan_counter u_counter (
    .clk     (CLK_SYS),
    .rst     (RESET),
    .load    (ctr_load),
    .seq_clr (ctr_seq_clr),
    .data    (WDATA),
    .dec     (ctr_dec),
    .count   (ctr_count),
    .tc      (ctr_tc)
  );

  assign TERM_COUNT = ctr_tc && mode_one[M1_CNT_EN];

  assign full  = valid[wsel];
  assign empty = !valid[rsel];

  always_comb begin
    if (ssc_on) begin
      cap_shift = cap_en && tck_rise && TCK_PERMIT && !mode_two[M2_STEP]
                  && seed_state == SCB_SEED_DONE;
    end else begin
      cap_shift = cap_en && !full && tck_rise && TCK_PERMIT
                  && !mode_two[M2_STEP];
    end
  end

  // A switch on terminal count with no bits taken would hand over an empty byte
  assign byte_done = !ssc_on && ((cap_shift && bit_cnt == LAST_BIT)
                     || (TERM_COUNT && (cap_shift || bit_cnt != 3'h0)));

  assign rd_ok   = RD && ADDR == ADR_CAPTURE && !empty && !ssc_on;
  assign seed_wr = WR && ADDR == ADR_CAPTURE && ssc_on;

  always_comb begin
    next_seed = seed_state;
    if (seed_wr) begin
      unique case (seed_state)
        SCB_SEED_HI:   next_seed = SCB_SEED_LO;
        SCB_SEED_LO:   next_seed = SCB_SEED_DONE;
        SCB_SEED_DONE: next_seed = SCB_SEED_LO;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET || soft_rst || ssc_rise) begin
      seed_state <= SCB_SEED_HI;
    end else begin
      seed_state <= next_seed;
    end
  end

  assign sig      = {cap_reg[1], cap_reg[0]};
  assign next_sig = ssc_step(sig, din);

  // A rewrite after seeding counts as a fresh high byte
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cap_reg[0] <= 8'h00;
      cap_reg[1] <= 8'h00;
    end else if (ssc_on) begin
      if (seed_wr) begin
        cap_reg[seed_state == SCB_SEED_LO ? 1'b0 : 1'b1] <= WDATA;
      end else if (cap_shift) begin
        cap_reg[1] <= next_sig[15:8];
        cap_reg[0] <= next_sig[7:0];
      end
    end else if (cap_shift) begin
      cap_reg[wsel] <= {din, cap_reg[wsel][7:1]};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET || soft_rst) begin
      bit_cnt <= 3'h0;
    end else if (byte_done || ssc_fall) begin
      bit_cnt <= 3'h0;
    end else if (cap_shift && !ssc_on) begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Two-entry FIFO: a filled byte and a drained byte never share an index
  always_ff @(posedge CLK_SYS) begin
    if (RESET || soft_rst) begin
      valid <= 2'b00;
      wsel  <= 1'b0;
      rsel  <= 1'b0;
    end else if (ssc_fall) begin
      valid <= 2'b11;
      wsel  <= 1'b0;
      rsel  <= 1'b1;
    end else begin
      if (byte_done) begin
        valid[wsel] <= 1'b1;
        wsel        <= !wsel;
      end
      if (rd_ok) begin
        valid[rsel] <= 1'b0;
        rsel        <= !rsel;
      end
    end
  end

  // Counter bytes read live; a read can see a byte mid-count
  always_comb begin
    next_rdata = 8'h00;
    if (RD) begin
      unique case (ADDR)
        ADR_CAPTURE:  next_rdata = rd_ok ? cap_reg[rsel] : 8'h00;
        ADR_MODE_ONE: next_rdata = mode_one;
        ADR_MODE_TWO: next_rdata = mode_two;
        ADR_STATUS:   next_rdata = {3'h0, ctr_count == 32'h0,
                                    seed_state == SCB_SEED_DONE, ssc_on, full, empty};
        ADR_CNT_B0:   next_rdata = ctr_count[7:0];
        ADR_CNT_B1:   next_rdata = ctr_count[15:8];
        ADR_CNT_B2:   next_rdata = ctr_count[23:16];
        ADR_CNT_B3:   next_rdata = ctr_count[31:24];
        default:      next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= next_rdata;
    end
  end

  assign CAPTURE_FULL  = full && !ssc_on;
  assign CAPTURE_EMPTY = empty || ssc_on;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence s_ssc_leave;
    ssc_prev && !ssc_on;
  endsequence

  sequence s_ssc_ready;
    valid == 2'b11 && rsel == 1'b1;
  endsequence

  a_read_ignored: assert property (RD && ADDR == ADR_CAPTURE && (empty || ssc_on)
    |=> RDATA == 8'h00 && $stable(valid))
    else $error("ignored capture read changed state");
  a_write_ignored: assert property (WR && ADDR == ADR_CAPTURE && !ssc_on && !cap_shift
    |=> $stable(sig))
    else $error("capture write taken outside compactor mode");
  a_shift_gate: assert property (cap_shift && !ssc_on
    |-> cap_en && !full && TCK_PERMIT && !mode_two[M2_STEP])
    else $error("shift without room or permit");
  a_byte_switch: assert property (cap_shift && !ssc_on && bit_cnt == LAST_BIT
    |=> wsel != $past(wsel) && valid[$past(wsel)])
    else $error("eighth bit did not switch register");
  a_tc_switch: assert property (TERM_COUNT && cap_shift && !ssc_on
    |=> wsel != $past(wsel) && bit_cnt == 3'h0)
    else $error("terminal count did not close byte");
  a_msb_entry: assert property (cap_shift && !ssc_on
    |=> cap_reg[$past(wsel)][7] == $past(din))
    else $error("bit did not enter at the top");
  a_seed_gate: assert property (ssc_on && seed_state != SCB_SEED_DONE |-> !cap_shift)
    else $error("compactor shifted before seeding");
  a_ssc_exit: assert property (s_ssc_leave |=> s_ssc_ready)
    else $error("leaving compactor did not fill buffer");
  a_loop_data: assert property (mode_one[1:0] == SCB_LB_DATA |-> din == TDO_OUT)
    else $error("loop-back did not select data shifter");
  a_step_once: assert property (step_pulse |=> !ctr_dec [*2])
    else $error("single step decremented more than once");
endmodule : scb_capture
`default_nettype wire

/* File: dv/scb_chain_model.sv */
// Behavioural scan chain that returns test data on the capture pin
`timescale 1ns/1ps
`default_nettype none
module scb_chain_model (
  input  wire logic        tck,
  input  wire logic        load,
  input  wire logic [31:0] pattern,
  output logic             tdi
);
  logic [31:0] sr;

  // Shifts on the falling edge so data is settled before the rising edge samples it
  always @(negedge tck or posedge load) begin
    if (load) begin
      sr <= pattern;
    end else begin
      // Stale bits come back inverted so old data never looks valid
      sr <= {~sr[0], sr[31:1]};
    end
  end

  assign tdi = sr[0];
endmodule : scb_chain_model
`default_nettype wire

/* File: dv/scb_capture_bench.sv */
// Self-checking bench for the capture buffer, compactor and scan-length counter
`timescale 1ns/1ps
`default_nettype none
module scb_capture_bench
  import scb_pkg::*;
;
  logic        clk, rst, wr, rd, tck, permit, src_a, src_b, src_d, ld;
  logic [3:0]  addr;
  logic [7:0]  wdata, d;
  logic [31:0] seed_r, pat, la, lb, lo, e, v;
  wire  [7:0]  rdata;
  wire         full, empty, tc, tdi;
  int          miscompares, check_count, cycles, tc_seen;

  scb_capture u_dut (
    .CLK_SYS(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .TDI(tdi), .TCK(tck), .TCK_PERMIT(permit), .TMS_A_OUT(src_a),
    .TMS_B_OUT(src_b), .TDO_OUT(src_d), .CAPTURE_FULL(full), .CAPTURE_EMPTY(empty),
    .TERM_COUNT(tc)
  );
  scb_chain_model u_chain (.tck(tck), .load(ld), .pattern(pat), .tdi(tdi));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function logic [31:0] rnd();
    seed_r ^= seed_r << 13;
    seed_r ^= seed_r >> 17;
    seed_r ^= seed_r << 5;
    return seed_r;
  endfunction : rnd

  function logic [15:0] sig_step(input logic [15:0] s, input logic b);
    return {s[14:0], 1'b0} ^ ((s[15] ^ b) ? SSC_POLY : 16'h0000);
  endfunction : sig_step

  task test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task wr_reg(input logic [3:0] a, input logic [7:0] dv);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= dv;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [3:0] a, output logic [7:0] q);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask : rd_reg

  task reload(input logic [31:0] p);
    @(posedge clk);
    pat <= p; ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
  endtask : reload

  // One bit per 200 ns link period: four system cycles low, four high
  task shift(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tck <= 1'b0; src_a <= la[i]; src_b <= lb[i]; src_d <= lo[i];
      repeat (3) @(posedge clk);
      @(posedge clk);
      tck <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    tck <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : shift

  task cnt_load(input logic [31:0] val);
    for (int i = 0; i < 4; i++) wr_reg(ADR_CNT_B0, val[8*i +: 8]);
  endtask : cnt_load

  task cnt_check(input logic [31:0] val);
    logic [7:0] q;
    for (int i = 0; i < 4; i++) begin
      rd_reg(ADR_CNT_B0 + 4'(i), q);
      check(q, val[8*i +: 8], "counter byte");
    end
  endtask : cnt_check

  // Terminal count is a one-cycle combinational pulse; count it mid-cycle to avoid a race
  always @(negedge clk) begin
    if (tc === 1'b1) tc_seen++;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles > 8000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00; tck = 1'b0;
    permit = 1'b1; src_a = 1'b0; src_b = 1'b0; src_d = 1'b0; ld = 1'b0; pat = 32'h0;
    la = 32'h0; lb = 32'h0; lo = 32'h0; seed_r = 32'hdf8df5e0;
    miscompares = 0; check_count = 0; cycles = 0; tc_seen = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ADR_STATUS, d);
    check(d, 8'h11, "status after reset");
    wr_reg(4'h9, 8'hff);
    rd_reg(4'h9, d);
    check(d, 8'h00, "unmapped read");
    cnt_check(32'h0);
    $display("test reset done");
    v = rnd();
    cnt_load(v);
    cnt_check(v);
    wr_reg(ADR_CNT_B0, 8'ha5);
    wr_reg(ADR_CNT_B0, 8'h5a);
    wr_reg(ADR_MODE_ONE, 8'h00);
    wr_reg(ADR_CNT_B0, 8'h3c);
    cnt_check({v[31:16], 8'h5a, 8'h3c});
    wr_reg(ADR_MODE_TWO, 8'h02);
    cnt_check({v[31:16], 8'h5a, 8'h3c});
    wr_reg(ADR_MODE_ONE, 8'h10);
    cnt_load(32'h0100_0000);
    wr_reg(ADR_MODE_TWO, 8'h01);
    repeat (4) @(posedge clk);
    cnt_check(32'h00ff_ffff);
    wr_reg(ADR_MODE_TWO, 8'h00);
    cnt_load(32'h0);
    wr_reg(ADR_MODE_TWO, 8'h01);
    cnt_check(32'h0);
    wr_reg(ADR_MODE_TWO, 8'h00);
    $display("test counter done");
    wr_reg(ADR_MODE_ONE, 8'h04);
    wr_reg(ADR_CAPTURE, 8'hff);
    @(negedge clk);
    check(empty, 1'b1, "write outside compactor");
    permit <= 1'b0;
    shift(8);
    check(empty, 1'b1, "no shift without permit");
    permit <= 1'b1;
    // Each loop-back code, code 0 being the returning chain data
    for (int c = 0; c < 4; c++) begin
      la = rnd(); lb = rnd(); lo = rnd(); v = rnd();
      reload(v);
      wr_reg(ADR_MODE_ONE, 8'h04 | 8'(c));
      shift(16);
      check(full, 1'b1, "full after two bytes");
      shift(4);
      e = (c == 0) ? v : (c == 1) ? la : (c == 2) ? lb : lo;
      rd_reg(ADR_CAPTURE, d);
      check(d, e[7:0], "first byte");
      rd_reg(ADR_CAPTURE, d);
      check(d, e[15:8], "second byte");
      rd_reg(ADR_CAPTURE, d);
      check(d, 8'h00, "read when empty");
      check(empty, 1'b1, "empty after reads");
    end
    $display("test capture done");
    v = rnd();
    reload(v);
    cnt_load(32'd5);
    tc_seen = 0;
    wr_reg(ADR_MODE_ONE, 8'h14);
    shift(5);
    check(tc_seen, 1, "terminal count pulses");
    rd_reg(ADR_CAPTURE, d);
    check(d & 8'hf8, {v[4:0], 3'b000}, "partial byte");
    cnt_check(32'h0);
    $display("test partial done");
    wr_reg(ADR_MODE_ONE, 8'h0c);
    e = rnd();
    wr_reg(ADR_CAPTURE, e[15:8]);
    reload(rnd());
    shift(4);
    rd_reg(ADR_STATUS, d);
    check(d[3:2], 2'b01, "compactor not seeded");
    wr_reg(ADR_CAPTURE, e[7:0]);
    rd_reg(ADR_CAPTURE, d);
    check(d, 8'h00, "read in compactor");
    v = rnd();
    reload(v);
    shift(8);
    for (int i = 0; i < 8; i++) e[15:0] = sig_step(e[15:0], v[i]);
    wr_reg(ADR_MODE_ONE, 8'h04);
    // The fill pulse follows the mode change by one cycle
    @(posedge clk);
    @(negedge clk);
    check(full, 1'b1, "full after compactor");
    rd_reg(ADR_CAPTURE, d);
    check(d, e[15:8], "signature high");
    rd_reg(ADR_CAPTURE, d);
    check(d, e[7:0], "signature low");
    $display("test compactor done");
    test_done();
  end
endmodule : scb_capture_bench
`default_nettype wire
